/* acq_cmd_pkg.sv */
/*
  Constants for the acquisition command handler: command codes, reply codes,
  field positions, mode and action encodings, settings limits.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package acq_cmd_pkg;
  localparam logic [15:0] CMD_RECONFIG     = 16'h0002;
  localparam logic [15:0] CMD_SET_MODE     = 16'h0003;
  localparam logic [15:0] CMD_GET_MODE     = 16'h0004;
  localparam logic [15:0] CMD_SET_SETTINGS = 16'h0005;
  localparam logic [15:0] CMD_GET_SETTINGS = 16'h0006;
  localparam logic [15:0] CMD_SET_ACTION   = 16'h0007;
  localparam logic [15:0] CMD_GET_ACTION   = 16'h0008;
  localparam logic [15:0] CMD_SET_TMASK    = 16'h0009;
  localparam logic [15:0] CMD_GET_TMASK    = 16'h000A;
  localparam logic [15:0] CMD_SRAM_WRITE   = 16'h000B;
  localparam logic [15:0] CMD_SRAM_READ    = 16'h000C;
  localparam logic [15:0] REPLY_FLAG       = 16'h8000;
  localparam logic [15:0] ERR_FW_UNKNOWN   = 16'h7F04;
  localparam logic [15:0] DST_BCAST        = 16'h8000;

  localparam logic [3:0] MODE_IDLE    = 4'h0;
  localparam logic [3:0] MODE_SCOPE   = 4'h1;
  localparam logic [3:0] MODE_SINGLES = 4'h2;
  localparam logic [3:0] ACT_RESET    = 4'h0;
  localparam logic [3:0] ACT_STOP     = 4'h1;
  localparam logic [3:0] ACT_RUN      = 4'h2;

  localparam logic [31:0] SETTINGS_RESET = 32'h0000_0000;
  localparam logic [31:0] TMASK_RESET    = 32'h0000_0000;
  localparam logic [31:0] SCOPE_FIELDS   = 32'h0F0F_1FF0;
  localparam logic [31:0] SINGLES_FIELDS = 32'h000F_000F;
  localparam logic [3:0]  SCOPE_FORMAT   = 4'h1;

  localparam int TOTAL_LSB = 4;
  localparam int TOTAL_W   = 9;
  localparam int PRE_LSB   = 16;
  localparam int WIN_LSB   = 24;
  localparam int INTEG_LSB = 0;
  localparam int START_LSB = 16;
  localparam int NIB_W     = 4;

  localparam int SINGLES_TRIG_BIN = 16;
  localparam int EVENT_TICKS      = 12;
  localparam int SLICE_WIDTH      = 4;
  localparam int PIPE_STAGES      = (EVENT_TICKS + SLICE_WIDTH - 1) / SLICE_WIDTH + 1;
endpackage : acq_cmd_pkg

/* acq_cmd_handler.sv */
/*
  Node-side command interpreter for acquisition control and SRAM access.
  Assumes commands arrive as a one-cycle strobe from logic on clk, that the
  SRAM answers a read with a one-cycle valid strobe, and that the flash
  loader reports completion with a one-cycle done strobe.
*/
// Contract
// - Reconfigure children on command and power-up
// - Set-mode stores payload bits 3:0
// - Get-mode returns stored mode
// - Set-settings stores word per current mode
// - Scope settings layout, format nibble 0001
// - Singles: integration length and start point
// - Singles trigger fixed at bin sixteen
// - Singles baseline spans bins zero to 16-B
// - Singles pipeline depth is build constant
// - Oversized settings clamp, reply shows clamp
// - Get-settings returns stored word
// - Set-action stores payload bits 3:0
// - Reset action restores mode and settings
// - Get-action returns stored action
// - Set-mask stores per-channel trigger enables
// - Get-mask returns stored mask
// - SRAM write stores payload, address increments
// - SRAM read at payload address, increments
// - Reply id has top bit set, except the unknown-command reply
// - Unknown command answered 0x7F04
// - Broadcast destination accepted like addressed
`timescale 1ns/1ps
`default_nettype none
module acq_cmd_handler
  import acq_cmd_pkg::*;
#(
  parameter int ADDR_W    = 20,
  parameter int MAX_TOTAL = 511
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Command in
  input  wire logic              cmd_valid,
  input  wire logic [15:0]       cmd_id,
  input  wire logic [15:0]       cmd_dst,
  input  wire logic [31:0]       cmd_payload,
  // Reply out
  output var  logic              rsp_valid,
  output var  logic [15:0]       rsp_id,
  output var  logic [15:0]       rsp_src,
  output var  logic [31:0]       rsp_payload,
  output var  logic              busy,
  // Child configuration loader
  output var  logic              cfg_start,
  input  wire logic              cfg_done,
  // External SRAM
  output var  logic              sram_we,
  output var  logic              sram_re,
  output var  logic [ADDR_W-1:0] sram_addr,
  output var  logic [31:0]       sram_wdata,
  input  wire logic              sram_rvalid,
  input  wire logic [31:0]       sram_rdata,
  // Acquisition controls
  output var  logic [3:0]        acq_mode,
  output var  logic [3:0]        acq_action,
  output var  logic [31:0]       acq_settings,
  output var  logic [31:0]       trig_enable,
  output var  logic [8:0]        scope_total,
  output var  logic [3:0]        scope_pre,
  output var  logic [3:0]        scope_window,
  output var  logic [3:0]        singles_length,
  output var  logic [3:0]        singles_start,
  output var  logic [4:0]        singles_trig_bin,
  output var  logic [4:0]        baseline_end,
  output var  logic [3:0]        pipe_depth
);

  initial begin
    if (ADDR_W < 1 || ADDR_W > 32) $error("ADDR_W out of range");
    if (MAX_TOTAL < 1 || MAX_TOTAL > 511) $error("MAX_TOTAL out of range");
  end

  typedef enum logic [3:0] {
    ST_BOOT  = 4'b0001,
    ST_CFG   = 4'b0010,
    ST_IDLE  = 4'b0100,
    ST_SRAMR = 4'b1000
  } state_t;

  typedef struct packed {
    state_t            st;
    logic              rsp_valid;
    logic [15:0]       rsp_id;
    logic [15:0]       rsp_src;
    logic [31:0]       rsp_payload;
    logic              cfg_start;
    logic              sram_we;
    logic              sram_re;
    logic [ADDR_W-1:0] addr;
    logic [31:0]       wdata;
    logic [3:0]        mode;
    logic [3:0]        action;
    logic [31:0]       settings;
    logic [31:0]       tmask;
    logic              cfg_pending;
    logic [15:0]       pend_id;
    logic [15:0]       pend_src;
    logic              busy;
    logic [ADDR_W-1:0] sram_addr;
    logic [4:0]        bline;
  } regs_t;

  regs_t q;
  regs_t d;

  logic [31:0] clamped;
  logic [8:0]  req_total;

  always_comb begin
    clamped   = 32'h0000_0000;
    req_total = cmd_payload[TOTAL_LSB +: TOTAL_W];
    if (q.mode == MODE_SCOPE) begin
      clamped = cmd_payload & SCOPE_FIELDS;
      clamped[NIB_W-1:0] = SCOPE_FORMAT;
      if (int'(req_total) > MAX_TOTAL) begin
        clamped[TOTAL_LSB +: TOTAL_W] = 9'(MAX_TOTAL);
      end
    end else if (q.mode == MODE_SINGLES) begin
      clamped = cmd_payload & SINGLES_FIELDS;
    end else begin
      clamped = cmd_payload;
    end
  end

  always_comb begin
    d           = q;
    d.rsp_valid = 1'b0;
    d.cfg_start = 1'b0;
    d.sram_we   = 1'b0;
    d.sram_re   = 1'b0;
    unique case (q.st)
      ST_BOOT: begin
        d.cfg_start = 1'b1;
        d.st        = ST_CFG;
      end
      ST_CFG: begin
        if (cfg_done) begin
          d.st = ST_IDLE;
          if (q.cfg_pending) begin
            d.rsp_valid   = 1'b1;
            d.rsp_id      = q.pend_id | REPLY_FLAG;
            d.rsp_src     = q.pend_src;
            d.rsp_payload = 32'h0000_0000;
            d.cfg_pending = 1'b0;
          end
        end
      end
      ST_SRAMR: begin
        if (sram_rvalid) begin
          d.st          = ST_IDLE;
          d.rsp_valid   = 1'b1;
          d.rsp_id      = q.pend_id | REPLY_FLAG;
          d.rsp_src     = q.pend_src;
          d.rsp_payload = sram_rdata;
        end
      end
      ST_IDLE: begin
        if (cmd_valid) begin
          // Broadcast bit does not change handling
          d.rsp_src  = cmd_dst;
          d.pend_src = cmd_dst;
          d.pend_id  = cmd_id;
          d.rsp_id      = cmd_id | REPLY_FLAG;
          d.rsp_valid   = 1'b1;
          d.rsp_payload = 32'h0000_0000;
          unique case (cmd_id)
            CMD_RECONFIG: begin
              d.rsp_valid   = 1'b0;
              d.cfg_start   = 1'b1;
              d.cfg_pending = 1'b1;
              d.st          = ST_CFG;
            end
            CMD_SET_MODE: begin
              d.mode        = cmd_payload[NIB_W-1:0];
              d.rsp_payload = {28'h000_0000, cmd_payload[NIB_W-1:0]};
            end
            CMD_GET_MODE: d.rsp_payload = {28'h000_0000, q.mode};
            CMD_SET_SETTINGS: begin
              d.settings    = clamped;
              d.rsp_payload = clamped;
            end
            CMD_GET_SETTINGS: d.rsp_payload = q.settings;
            CMD_SET_ACTION: begin
              d.action      = cmd_payload[NIB_W-1:0];
              d.rsp_payload = {28'h000_0000, cmd_payload[NIB_W-1:0]};
              if (cmd_payload[NIB_W-1:0] == ACT_RESET) begin
                d.mode     = MODE_IDLE;
                d.settings = SETTINGS_RESET;
              end
            end
            CMD_GET_ACTION: d.rsp_payload = {28'h000_0000, q.action};
            CMD_SET_TMASK: begin
              d.tmask       = cmd_payload;
              d.rsp_payload = cmd_payload;
            end
            CMD_GET_TMASK: d.rsp_payload = q.tmask;
            CMD_SRAM_WRITE: begin
              d.sram_we     = 1'b1;
              d.wdata       = cmd_payload;
              d.addr        = q.addr + 1'b1;
              d.rsp_payload = cmd_payload;
            end
            CMD_SRAM_READ: begin
              // Read at given address then advance
              d.rsp_valid = 1'b0;
              d.sram_re   = 1'b1;
              d.addr      = cmd_payload[ADDR_W-1:0];
              d.st        = ST_SRAMR;
            end
            default: begin
              d.rsp_id = ERR_FW_UNKNOWN;
            end
          endcase
        end
      end
      default: d.st = ST_IDLE;
    endcase
    // Address advance when the read data returns
    if (q.st == ST_SRAMR && sram_rvalid) begin
      d.addr = q.addr + 1'b1;
    end
    // Access address: write at old address, read at payload
    if (d.sram_we || d.sram_re) begin
      d.sram_addr = d.sram_re ? d.addr : q.addr;
    end
    // Baseline end is 16 minus B
    d.bline = 5'(SINGLES_TRIG_BIN) - {1'b0, d.settings[START_LSB +: NIB_W]};
    d.busy  = (d.st != ST_IDLE);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q             <= '0;
      q.st          <= ST_BOOT;
      q.mode        <= MODE_IDLE;
      q.action      <= ACT_RESET;
      q.settings    <= SETTINGS_RESET;
      q.tmask       <= TMASK_RESET;
      q.busy        <= 1'b1;
      q.bline       <= 5'(SINGLES_TRIG_BIN);
    end else begin
      q <= d;
    end
  end

  assign rsp_valid      = q.rsp_valid;
  assign rsp_id         = q.rsp_id;
  assign rsp_src        = q.rsp_src;
  assign rsp_payload    = q.rsp_payload;
  assign busy           = q.busy;
  assign cfg_start      = q.cfg_start;
  assign sram_we        = q.sram_we;
  assign sram_re        = q.sram_re;
  assign sram_addr      = q.sram_addr;
  assign sram_wdata     = q.wdata;
  assign acq_mode       = q.mode;
  assign acq_action     = q.action;
  assign acq_settings   = q.settings;
  assign trig_enable    = q.tmask;
  assign scope_total    = q.settings[TOTAL_LSB +: TOTAL_W];
  assign scope_pre      = q.settings[PRE_LSB +: NIB_W];
  assign scope_window   = q.settings[WIN_LSB +: NIB_W];
  assign singles_length = q.settings[INTEG_LSB +: NIB_W];
  assign singles_start  = q.settings[START_LSB +: NIB_W];
  assign singles_trig_bin = 5'(SINGLES_TRIG_BIN);
  assign baseline_end   = q.bline;
  assign pipe_depth     = 4'(PIPE_STAGES);

  a_reply_flag: assert property (@(posedge clk) disable iff (!rst_n)
    rsp_valid && rsp_id != ERR_FW_UNKNOWN |-> rsp_id[15]);
  a_mode_echo: assert property (@(posedge clk) disable iff (!rst_n)
    q.st == ST_IDLE && cmd_valid && cmd_id == CMD_GET_MODE |=> rsp_valid && rsp_payload == {28'h0, $past(q.mode)});
  a_mode_store: assert property (@(posedge clk) disable iff (!rst_n)
    q.st == ST_IDLE && cmd_valid && cmd_id == CMD_SET_MODE |=> acq_mode == $past(cmd_payload[3:0]));
  a_reset_defaults: assert property (@(posedge clk) disable iff (!rst_n)
    q.st == ST_IDLE && cmd_valid && cmd_id == CMD_SET_ACTION && cmd_payload[3:0] == ACT_RESET
    |=> acq_mode == MODE_IDLE && acq_settings == SETTINGS_RESET);
  a_unknown_err: assert property (@(posedge clk) disable iff (!rst_n)
    q.st == ST_IDLE && cmd_valid && cmd_id == 16'h0001 |=> rsp_valid && rsp_id == ERR_FW_UNKNOWN);
  a_mask_echo: assert property (@(posedge clk) disable iff (!rst_n)
    q.st == ST_IDLE && cmd_valid && cmd_id == CMD_GET_TMASK |=> rsp_valid && rsp_payload == $past(trig_enable));
  a_wr_advance: assert property (@(posedge clk) disable iff (!rst_n)
    q.st == ST_IDLE && cmd_valid && cmd_id == CMD_SRAM_WRITE |=> sram_we && q.addr == $past(q.addr) + 1'b1);
  a_scope_clamp: assert property (@(posedge clk) disable iff (!rst_n)
    q.st == ST_IDLE && cmd_valid && cmd_id == CMD_SET_SETTINGS && q.mode == MODE_SCOPE
    |=> int'(scope_total) <= MAX_TOTAL && rsp_payload == acq_settings);
  a_boot_cfg: assert property (@(posedge clk)
    !rst_n ##1 rst_n |=> cfg_start);
  a_trig_bin: assert property (@(posedge clk) disable iff (!rst_n)
    singles_trig_bin == 5'd16);
  a_mask_store: assert property (@(posedge clk) disable iff (!rst_n)
    q.st == ST_IDLE && cmd_valid && cmd_id == CMD_SET_TMASK |=> trig_enable == $past(cmd_payload));
  a_baseline_end: assert property (@(posedge clk) disable iff (!rst_n)
    baseline_end == 5'(SINGLES_TRIG_BIN) - {1'b0, singles_start});
  a_busy_refuse: assert property (@(posedge clk) disable iff (!rst_n)
    busy && cmd_valid
    |=> acq_mode == $past(acq_mode) && trig_enable == $past(trig_enable) && acq_settings == $past(acq_settings));
  a_read_return: assert property (@(posedge clk) disable iff (!rst_n)
    q.st == ST_SRAMR && sram_rvalid
    |=> rsp_valid && rsp_payload == $past(sram_rdata) && q.addr == $past(q.addr) + 1'b1);
  a_settings_echo: assert property (@(posedge clk) disable iff (!rst_n)
    q.st == ST_IDLE && cmd_valid && cmd_id == CMD_GET_SETTINGS |=> rsp_valid && rsp_payload == $past(acq_settings));
  a_action_echo: assert property (@(posedge clk) disable iff (!rst_n)
    q.st == ST_IDLE && cmd_valid && cmd_id == CMD_GET_ACTION |=> rsp_payload == {28'h000_0000, $past(acq_action)});
  a_singles_fields: assert property (@(posedge clk) disable iff (!rst_n)
    q.st == ST_IDLE && cmd_valid && cmd_id == CMD_SET_SETTINGS && q.mode == MODE_SINGLES
    |=> acq_settings == ($past(cmd_payload) & SINGLES_FIELDS));

endmodule : acq_cmd_handler
`default_nettype wire

/* acq_far_side_model.sv */
/* Far-side model: child configuration loader and external SRAM.
   Assumes one-cycle registered start, write and read strobes on clk. */
`timescale 1ns/1ps
`default_nettype none
module acq_far_side_model #(
  parameter int ADDR_W  = 20,
  parameter int CFG_LAT = 6
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Loader
  input  wire logic              cfg_start,
  output var  logic              cfg_done,
  // SRAM
  input  wire logic              sram_we,
  input  wire logic              sram_re,
  input  wire logic [ADDR_W-1:0] sram_addr,
  input  wire logic [31:0]       sram_wdata,
  output var  logic              sram_rvalid,
  output var  logic [31:0]       sram_rdata
);
  logic [31:0] mem [int];
  logic [31:0] rd_word;
  int          cfg_cnt;
  int          rd_cnt;
  logic        slow;

  initial begin
    cfg_done    = 1'b0;
    sram_rvalid = 1'b0;
    sram_rdata  = '0;
    slow        = 1'b0;
  end

  always @(posedge clk) begin
    cfg_done    <= 1'b0;
    sram_rvalid <= 1'b0;
    // Data line toggles while not valid
    sram_rdata  <= ~sram_rdata;
    if (!rst_n) begin
      cfg_cnt <= 0;
      rd_cnt  <= 0;
    end else begin
      cfg_cnt <= cfg_start ? CFG_LAT : (cfg_cnt > 0 ? cfg_cnt - 1 : 0);
      if (cfg_cnt == 1) begin
        cfg_done <= 1'b1;
      end
      if (sram_we) begin
        mem[int'(sram_addr)] = sram_wdata;
      end
      rd_cnt <= sram_re ? (slow ? 4 : 1) : (rd_cnt > 0 ? rd_cnt - 1 : 0);
      if (sram_re) begin
        rd_word <= mem.exists(int'(sram_addr)) ? mem[int'(sram_addr)] : 32'hDEAD_0000;
        slow    <= ~slow;
      end
      if (rd_cnt == 1) begin
        sram_rvalid <= 1'b1;
        sram_rdata  <= rd_word;
      end
    end
  end
endmodule : acq_far_side_model
`default_nettype wire

/* acquisition_command_handler_test.sv */
/* Bench for the acquisition command handler: reset, then register rows,
   reconfigure, refusal, unknown-command and SRAM tests.
   Assumes the far-side model as loader and SRAM. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin fail_count++; \
  $display("[FAIL] %0t got %h exp %h", $time, (got), (exp)); end end
module acquisition_command_handler_test;
  import acq_cmd_pkg::*;
  localparam int          AW   = 20;
  localparam int          MAXT = 100;
  localparam logic [15:0] BC   = 16'h8003;
  localparam logic [15:0] ND   = 16'h0005;
  typedef struct packed {
    logic [15:0] id;
    logic [15:0] dst;
    logic [31:0] pl;
    logic [31:0] exp;
  } row_t;
  localparam int   NR = 18;
  localparam row_t ROWS [NR] = '{
    '{CMD_GET_MODE,     ND, 32'hDEAD_FEED, 32'h0},
    '{CMD_GET_SETTINGS, ND, 32'hDEAD_FEED, 32'h0},
    '{CMD_GET_ACTION,   ND, 32'hDEAD_FEED, 32'h0},
    '{CMD_GET_TMASK,    ND, 32'hDEAD_FEED, 32'h0},
    '{CMD_SET_MODE,     BC, 32'hFFFF_FFF1, 32'h1}, // broadcast mode write
    '{CMD_GET_MODE,     ND, 32'h0,         32'h1},
    '{CMD_SET_SETTINGS, BC, 32'h0200_0101, 32'h0200_0101}, // total in range
    '{CMD_SET_SETTINGS, BC, 32'hFFFF_FFF0, 32'h0F0F_0001 | (32'(MAXT) << TOTAL_LSB)},
    '{CMD_GET_SETTINGS, ND, 32'h0,         32'h0F0F_0001 | (32'(MAXT) << TOTAL_LSB)},
    '{CMD_SET_MODE,     BC, 32'h0000_0002, 32'h2},
    '{CMD_SET_SETTINGS, BC, 32'hFFFF_FFFF, 32'h000F_000F}, // length above one
    '{CMD_SET_TMASK,    ND, 32'h0000_0121, 32'h0000_0121},
    '{CMD_SET_ACTION,   BC, 32'hFFFF_FFF1, 32'h1},
    '{CMD_GET_ACTION,   ND, 32'h0,         32'h1},
    '{CMD_SET_ACTION,   BC, 32'h0000_0002, 32'h2},
    '{CMD_SET_ACTION,   BC, 32'h0000_0000, 32'h0},
    '{CMD_GET_MODE,     ND, 32'h0,         32'h0},
    '{CMD_GET_SETTINGS, ND, 32'h0,         32'h0}
  };
  // Bench signals
  logic          clk         = 1'b0;
  logic          rst_n       = 1'b0;
  logic          cmd_valid   = 1'b0;
  logic [15:0]   cmd_id      = '0;
  logic [15:0]   cmd_dst     = '0;
  logic [31:0]   cmd_payload = '0;
  logic          rsp_valid, busy, cfg_start, cfg_done, sram_we, sram_re, sram_rvalid;
  logic [15:0]   rsp_id, rsp_src, r_id, r_src;
  logic [31:0]   rsp_payload, r_pl, sram_wdata, sram_rdata, trig_enable, acq_settings;
  logic [AW-1:0] sram_addr;
  logic [3:0]    acq_mode, acq_action, pipe_depth;
  logic [4:0]    singles_trig_bin, baseline_end;
  int            fail_count  = 0;
  int            check_count = 0;
  int            starts      = 0;
  int            n;

  acq_cmd_handler #(.ADDR_W(AW), .MAX_TOTAL(MAXT)) i_dut (
    .clk(clk), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_id(cmd_id), .cmd_dst(cmd_dst),
    .cmd_payload(cmd_payload), .rsp_valid(rsp_valid), .rsp_id(rsp_id), .rsp_src(rsp_src),
    .rsp_payload(rsp_payload), .busy(busy), .cfg_start(cfg_start), .cfg_done(cfg_done),
    .sram_we(sram_we), .sram_re(sram_re), .sram_addr(sram_addr), .sram_wdata(sram_wdata),
    .sram_rvalid(sram_rvalid), .sram_rdata(sram_rdata), .acq_mode(acq_mode), .acq_action(acq_action),
    .acq_settings(acq_settings), .trig_enable(trig_enable), .scope_total(), .scope_pre(), .scope_window(),
    .singles_length(), .singles_start(), .singles_trig_bin(singles_trig_bin), .baseline_end(baseline_end),
    .pipe_depth(pipe_depth));

  acq_far_side_model #(.ADDR_W(AW)) i_far (
    .clk(clk), .rst_n(rst_n), .cfg_start(cfg_start), .cfg_done(cfg_done), .sram_we(sram_we),
    .sram_re(sram_re), .sram_addr(sram_addr), .sram_wdata(sram_wdata),
    .sram_rvalid(sram_rvalid), .sram_rdata(sram_rdata));

  always #25 clk = ~clk;

  always @(posedge clk) begin
    if (cfg_start === 1'b1) starts <= starts + 1;
  end

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up

  task automatic wait_reply();
    while (rsp_valid !== 1'b1 && n < 400) begin
      @(posedge clk);
      #5;
      n++;
    end
    if (n >= 400) begin
      fail_count++;
      wrap_up();
    end else begin
      r_id  = rsp_id;
      r_src = rsp_src;
      r_pl  = rsp_payload;
    end
  endtask : wait_reply

  task automatic send(input logic [15:0] id, input logic [15:0] dst, input logic [31:0] pl);
    n = 0;
    @(posedge clk);
    #5;
    while (busy !== 1'b0 && n < 400) begin
      @(posedge clk);
      #5;
      n++;
    end
    cmd_id      = id;
    cmd_dst     = dst;
    cmd_payload = pl;
    cmd_valid   = 1'b1;
    @(posedge clk);
    #5;
    cmd_valid   = 1'b0;
    wait_reply();
  endtask : send

  initial begin
    repeat (20) @(posedge clk);
    #5;
    rst_n = 1'b1;
    repeat (12) @(posedge clk);
    #5;
    `CHK(starts, 1) // boot load started
    `CHK(busy, 1'b0) // boot load finished
    $display("test reset done");
    for (int i = 0; i < NR; i++) begin
      send(ROWS[i].id, ROWS[i].dst, ROWS[i].pl);
      `CHK(r_id, ROWS[i].id | REPLY_FLAG) // reply id
      `CHK(r_src, ROWS[i].dst) // source echo
      `CHK(r_pl, ROWS[i].exp) // values
    end
    `CHK(trig_enable, 32'h0000_0121) // mask drives enables
    `CHK(acq_mode, MODE_IDLE) // mode back to idle
    `CHK(acq_settings, SETTINGS_RESET) // settings back to default
    `CHK(acq_action, ACT_RESET) // action stored
    `CHK(singles_trig_bin, 5'd16) // fixed trigger bin
    `CHK(pipe_depth, 4'((EVENT_TICKS + SLICE_WIDTH - 1) / SLICE_WIDTH + 1)) // pipeline depth
    send(CMD_SET_MODE, BC, 32'h0000_0002); // broadcast mode write
    send(CMD_SET_SETTINGS, BC, 32'h0003_0004); // length above one
    `CHK(acq_settings, 32'h0003_0004) // singles fields kept
    `CHK(baseline_end, 5'd13) // baseline ends at 16-B
    $display("test rows done");
    // Reconfigure, with a mask write offered while busy
    @(posedge clk);
    #5;
    cmd_id    = CMD_RECONFIG;
    cmd_dst   = 16'h0800;
    cmd_valid = 1'b1;
    @(posedge clk);
    #5;
    cmd_id      = CMD_SET_TMASK;
    cmd_payload = 32'hFFFF_FFFF;
    @(posedge clk);
    #5;
    cmd_valid = 1'b0;
    n         = 0;
    wait_reply();
    `CHK(r_id, CMD_RECONFIG | REPLY_FLAG) // reconfigure reply id
    `CHK(r_pl, 32'h0) // reconfigure reply payload
    `CHK(starts, 2) // command load started
    send(CMD_GET_TMASK, ND, '0);
    `CHK(r_pl, 32'h0000_0121) // busy write refused
    for (int i = 0; i < 2; i++) begin
      send(i ? 16'h000D : 16'h0001, 16'h0002, '0);
      `CHK(r_id, ERR_FW_UNKNOWN) // unknown command
    end
    $display("test reconfigure done");
    // SRAM write and read, run with action left at reset; the handler does not check action
    for (int i = 0; i < 3; i++) begin
      send(CMD_SRAM_WRITE, 16'h0001, 32'h1234_5670 + i);
      `CHK(sram_we, 1'b1) // write strobe
      `CHK(sram_wdata, 32'h1234_5670 + i) // write data
      `CHK(sram_addr, AW'(i)) // address advances
      `CHK(r_pl, 32'h1234_5670 + i) // payload echo
    end
    send(CMD_SRAM_READ, 16'h0001, 32'h0000_0001);
    `CHK(r_id, CMD_SRAM_READ | REPLY_FLAG) // read reply id
    `CHK(r_pl, 32'h1234_5671) // word at payload address
    send(CMD_SRAM_WRITE, 16'h0001, 32'hCAFE_0002);
    `CHK(sram_addr, AW'(2)) // read advances address
    send(CMD_SRAM_READ, 16'h0001, 32'h0000_0002);
    `CHK(r_pl, 32'hCAFE_0002) // overwritten word
    send(CMD_SRAM_READ, 16'h0001, 32'h0);
    `CHK(r_pl, 32'h1234_5670) // first word kept
    $display("test sram done");
    wrap_up();
  end
endmodule : acquisition_command_handler_test
`default_nettype wire
